/* rtl/emt_regs.svh */
/*
 * Timing constants for the effective-address and move cycle sequencer.
 * Assumes inclusion by bare name from the design file and the testbench.
 */
`ifndef EMT_REGS_SVH
`define EMT_REGS_SVH
// Periods of one zero-wait bus cycle.
`define EMT_BUS_PERIODS 4
// Clock period of the core clock in nanoseconds.
`define EMT_CLK_NS 20
// Addressing mode codes.
`define EMT_M_DREG   4'h0
`define EMT_M_AREG   4'h1
`define EMT_M_IND    4'h2
`define EMT_M_POST   4'h3
`define EMT_M_PRE    4'h4
`define EMT_M_D16    4'h5
`define EMT_M_IDX    4'h6
`define EMT_M_ABSW   4'h7
`define EMT_M_ABSL   4'h8
`define EMT_M_PCD    4'h9
`define EMT_M_PCX    4'hA
`define EMT_M_IMM    4'hB
// Operation codes.
`define EMT_OP_EA    2'h0
`define EMT_OP_MOVE  2'h1
// Base cost of a register-to-register byte or word move.
`define EMT_MOVE_BASE_CLK 6'h04
`define EMT_MOVE_BASE_RD  3'h1
`endif

/* rtl/emt_pkg.sv */
/*
 * Types for the effective-address and move cycle sequencer.
 * Assumes the constants header is on the include path.
 */
package emt_pkg;
    // Sequencer states, one-hot.
    typedef enum logic [3:0] {
        EMT_IDLE  = 4'b0001,
        EMT_READ  = 4'b0010,
        EMT_WRITE = 4'b0100,
        EMT_INTL  = 4'b1000
    } emt_state_t;
    // Cost triple of one operation: periods, reads, writes.
    typedef struct packed {
        logic [5:0] clk;
        logic [2:0] rd;
        logic [2:0] wr;
    } emt_cost_t;
endpackage

/* rtl/emt_seq.sv */
/*
 * Cycle sequencer for effective-address calculation and byte/word moves.
 * It looks up the cost of a requested operation, runs the bus reads and
 * writes as four-period cycles stretched by wait states, then idles for
 * the remaining internal periods. Assumes a memory that answers with a
 * ready level synchronous to clk and req held only while idle.
 */
// Summary of operation
// - Zero-wait bus cycle lasts four clocks.
// - Each stretch period adds one wait state.
// - Report total clocks, reads and writes.
// - Totals include fetch and operand accesses.
// - Leftover periods keep the bus idle.
// - Address calculation never writes.
// - Indirect: 4/1, 8/2, 2/0.
// - Postincrement: 4/1, 8/2, 4/0.
// - Predecrement: 6/1, 10/2, 4/0.
// - Displacement: 8/2, 12/3, 4/1.
// - Indexed: 10/2, 14/3, 8/1.
// - Absolute long: 12/3, 16/4, 8/2.
// - PC displacement: 8/2, 12/3.
// - PC indexed 10/14; immediate 4/8.
// - Index size never changes clock count.
// - Register move 4/1 plus source fetch.
// - Destination adds per-mode clocks and accesses.
`include "emt_regs.svh"
module emt_seq
    import emt_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       reset,
    // Request from the instruction decoder.
    input  wire logic       req,
    input  wire logic [1:0] op,
    input  wire logic [3:0] src_mode,
    input  wire logic [3:0] dst_mode,
    input  wire logic       long_sz,
    input  wire logic       fetch,
    input  wire logic       idx_long,
    // Memory side.
    input  wire logic       mem_ready,
    output logic            bus_rd,
    output logic            bus_wr,
    // Status and results.
    output logic            busy,
    output logic            done,
    output logic [5:0]      res_clk,
    output logic [2:0]      res_rd,
    output logic [2:0]      res_wr,
    output logic [7:0]      wait_cnt,
    output logic            bad_req
);
    // Synchronised memory ready.
    logic             rdy_s1_q;
    logic             rdy_s2_q;
    logic [1:0]       ph_q;
    logic [5:0]       left_q;
    logic [2:0]       rd_left_q;
    logic [2:0]       wr_left_q;
    logic [7:0]       wait_q;
    emt_state_t       st_q;
    emt_state_t       st_d;
    emt_cost_t        src_c;
    emt_cost_t        dst_c;
    emt_cost_t        tot_c;
    logic             src_ok;
    logic             dst_ok;
    logic             req_ok;
    logic             ph_last;
    logic             stretch;

    // Source/EA cost lookup; idx_long is ignored on purpose.
    // index size ignored
    function automatic emt_cost_t ea_cost(input logic [3:0] m, input logic lg,
                                          input logic f, output logic ok);
        emt_cost_t c;
        c  = '{clk: 6'h00, rd: 3'h0, wr: 3'h0};
        ok = 1'b1;
        case (m)
            `EMT_M_DREG, `EMT_M_AREG: c = '{6'h00, 3'h0, 3'h0};
            `EMT_M_IND:  c = !f ? '{6'h02, 3'h0, 3'h0} : lg ? '{6'h08, 3'h2, 3'h0}
                                                              : '{6'h04, 3'h1, 3'h0};
            `EMT_M_POST: c = !f ? '{6'h04, 3'h0, 3'h0} : lg ? '{6'h08, 3'h2, 3'h0}
                                                              : '{6'h04, 3'h1, 3'h0};
            `EMT_M_PRE:  c = !f ? '{6'h04, 3'h0, 3'h0} : lg ? '{6'h0A, 3'h2, 3'h0}
                                                              : '{6'h06, 3'h1, 3'h0};
            `EMT_M_D16, `EMT_M_ABSW:
                         c = !f ? '{6'h04, 3'h1, 3'h0} : lg ? '{6'h0C, 3'h3, 3'h0}
                                                              : '{6'h08, 3'h2, 3'h0};
            `EMT_M_IDX:  c = !f ? '{6'h08, 3'h1, 3'h0} : lg ? '{6'h0E, 3'h3, 3'h0}
                                                              : '{6'h0A, 3'h2, 3'h0};
            `EMT_M_ABSL: c = !f ? '{6'h08, 3'h2, 3'h0} : lg ? '{6'h10, 3'h4, 3'h0}
                                                              : '{6'h0C, 3'h3, 3'h0};
            `EMT_M_PCD: begin
                ok = f;
                c  = lg ? '{6'h0C, 3'h3, 3'h0} : '{6'h08, 3'h2, 3'h0};
            end
            `EMT_M_PCX: begin
                ok = f;
                c  = lg ? '{6'h0E, 3'h3, 3'h0} : '{6'h0A, 3'h2, 3'h0};
            end
            `EMT_M_IMM: begin
                ok = f;
                c  = lg ? '{6'h08, 3'h2, 3'h0} : '{6'h04, 3'h1, 3'h0};
            end
            default: ok = 1'b0;
        endcase
        return c;
    endfunction

    // Destination surcharge of a byte or word move.
    // destination surcharge
    function automatic emt_cost_t dst_cost(input logic [3:0] m, output logic ok);
        emt_cost_t c;
        c  = '{clk: 6'h00, rd: 3'h0, wr: 3'h0};
        ok = 1'b1;
        case (m)
            `EMT_M_DREG, `EMT_M_AREG:           c = '{6'h00, 3'h0, 3'h0};
            `EMT_M_IND, `EMT_M_POST, `EMT_M_PRE: c = '{6'h04, 3'h0, 3'h1};
            `EMT_M_D16, `EMT_M_ABSW:            c = '{6'h08, 3'h1, 3'h1};
            `EMT_M_IDX:                         c = '{6'h0A, 3'h1, 3'h1};
            `EMT_M_ABSL:                        c = '{6'h0C, 3'h2, 3'h1};
            default:                            ok = 1'b0;
        endcase
        return c;
    endfunction

    // Combined cost of the request; address calculation adds no writes.
    always_comb begin
        src_c  = ea_cost(src_mode, long_sz, (op == `EMT_OP_MOVE) | fetch, src_ok);
        dst_c  = dst_cost(dst_mode, dst_ok);
        tot_c  = src_c;
        req_ok = src_ok;
        if (op == `EMT_OP_MOVE) begin
            tot_c.clk = src_c.clk + `EMT_MOVE_BASE_CLK + dst_c.clk;
            tot_c.rd  = src_c.rd + `EMT_MOVE_BASE_RD + dst_c.rd;
            tot_c.wr  = dst_c.wr;
            req_ok    = src_ok & dst_ok & ~long_sz;
        end else begin
            tot_c.wr  = 3'h0;
            req_ok    = src_ok & (op == `EMT_OP_EA);
        end
    end

    // Phase bookkeeping: the fourth phase ends a cycle unless memory stretches it.
    assign ph_last = (ph_q == 2'h3);
    assign stretch = ph_last & ~rdy_s2_q & (st_q == EMT_READ || st_q == EMT_WRITE);

    // Next state: reads first, then writes, then idle internal periods.
    always_comb begin
        st_d = st_q;
        case (st_q)
            EMT_IDLE: begin
                if (req && req_ok) begin
                    st_d = (tot_c.rd != 3'h0) ? EMT_READ :
                           (tot_c.wr != 3'h0) ? EMT_WRITE :
                           (tot_c.clk != 6'h00) ? EMT_INTL : EMT_IDLE;
                end
            end
            EMT_READ, EMT_WRITE: begin
                if (ph_last && !stretch) begin
                    st_d = (rd_left_q > 3'h1 && st_q == EMT_READ) ? EMT_READ :
                           ((st_q == EMT_READ ? wr_left_q : wr_left_q - 3'h1) != 3'h0)
                               ? EMT_WRITE :
                           (left_q > 6'h01) ? EMT_INTL : EMT_IDLE;
                end
            end
            EMT_INTL: begin
                if (left_q == 6'h01) begin
                    st_d = EMT_IDLE;
                end
            end
            default: st_d = EMT_IDLE;
        endcase
    end

    // Ready synchroniser; only the second stage is read.
    always_ff @(posedge clk) begin
        rdy_s1_q <= reset ? 1'b0 : mem_ready;
        rdy_s2_q <= reset ? 1'b0 : rdy_s1_q;
    end

    // Sequencer registers and counters.
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q      <= EMT_IDLE;
            ph_q      <= 2'h0;
            left_q    <= 6'h00;
            rd_left_q <= 3'h0;
            wr_left_q <= 3'h0;
            wait_q    <= 8'h00;
        end else begin
            st_q <= st_d;
            if (st_q == EMT_IDLE) begin
                ph_q      <= 2'h0;
                left_q    <= tot_c.clk;
                rd_left_q <= tot_c.rd;
                wr_left_q <= tot_c.wr;
                if (req && req_ok) begin
                    wait_q <= 8'h00;
                end
            end else if (stretch) begin
                wait_q <= wait_q + 8'h01;
            end else begin
                ph_q   <= ph_q + 2'h1;
                left_q <= left_q - 6'h01;
                if (ph_last && st_q == EMT_READ) begin
                    rd_left_q <= rd_left_q - 3'h1;
                end
                if (ph_last && st_q == EMT_WRITE) begin
                    wr_left_q <= wr_left_q - 3'h1;
                end
            end
        end
    end

    // Outputs, all registered.
    always_ff @(posedge clk) begin
        if (reset) begin
            bus_rd   <= 1'b0;
            bus_wr   <= 1'b0;
            busy     <= 1'b0;
            done     <= 1'b0;
            res_clk  <= 6'h00;
            res_rd   <= 3'h0;
            res_wr   <= 3'h0;
            wait_cnt <= 8'h00;
            bad_req  <= 1'b0;
        end else begin
            bus_rd   <= (st_d == EMT_READ);
            bus_wr   <= (st_d == EMT_WRITE);
            busy     <= (st_d != EMT_IDLE);
            done     <= (st_q != EMT_IDLE) && (st_d == EMT_IDLE);
            wait_cnt <= wait_q;
            bad_req  <= (st_q == EMT_IDLE) && req && !req_ok;
            if (st_q == EMT_IDLE && req && req_ok) begin
                res_clk <= tot_c.clk;
                res_rd  <= tot_c.rd;
                res_wr  <= tot_c.wr;
            end
        end
    end

    // Checks on the sequencer.
    // With no write left to run, an accepted address calculation can never write.
    chk_no_ea_write: assert property (@(posedge clk) disable iff (reset)
        (st_q == EMT_IDLE && req && req_ok && op == `EMT_OP_EA)
        |=> (wr_left_q == 3'h0 && !bus_wr))
        else $error("Address calculation drove a write.");
    chk_cycle_four: assert property (@(posedge clk) disable iff (reset)
        ($rose(bus_rd) && rdy_s2_q) |-> bus_rd [*4])
        else $error("Read cycle shorter than four periods.");
    chk_write_four: assert property (@(posedge clk) disable iff (reset)
        ($rose(bus_wr) && rdy_s2_q) |-> bus_wr [*4])
        else $error("Write cycle shorter than four periods.");
    // Internal periods follow the last bus cycle, or the idle state when there is none, with the bus quiet.
    chk_intl_quiet: assert property (@(posedge clk) disable iff (reset)
        (st_q == EMT_INTL)
        |-> (rd_left_q == 3'h0 && wr_left_q == 3'h0 && !bus_rd && !bus_wr))
        else $error("Bus active during internal periods.");
    chk_ind_fetch: assert property (@(posedge clk) disable iff (reset)
        (st_q == EMT_IDLE && req && op == `EMT_OP_EA && src_mode == `EMT_M_IND
         && fetch && !long_sz) |=> (res_clk == 6'h04 && res_rd == 3'h1))
        else $error("Indirect fetch cost wrong.");
    chk_idx_size: assert property (@(posedge clk) disable iff (reset)
        (src_mode == `EMT_M_IDX && fetch && op == `EMT_OP_EA && !long_sz)
        |-> tot_c.clk == 6'h0A)
        else $error("Indexed cost depends on index size.");
    chk_move_base: assert property (@(posedge clk) disable iff (reset)
        (op == `EMT_OP_MOVE && src_mode == `EMT_M_DREG && dst_mode == `EMT_M_DREG)
        |-> (tot_c.clk == 6'h04 && tot_c.rd == 3'h1 && tot_c.wr == 3'h0))
        else $error("Register move cost wrong.");
    chk_move_absl: assert property (@(posedge clk) disable iff (reset)
        (op == `EMT_OP_MOVE && src_mode == `EMT_M_DREG && dst_mode == `EMT_M_ABSL
         && !long_sz) |-> (tot_c.clk == 6'h10 && tot_c.rd == 3'h3 && tot_c.wr == 3'h1))
        else $error("Absolute long destination cost wrong.");
    chk_wait_count: assert property (@(posedge clk) disable iff (reset)
        stretch |=> wait_q == $past(wait_q) + 8'h01)
        else $error("Wait state not counted.");
    chk_pre_cost: assert property (@(posedge clk) disable iff (reset)
        (op == `EMT_OP_EA && src_mode == `EMT_M_PRE && fetch && long_sz)
        |-> (tot_c.clk == 6'h0A && tot_c.rd == 3'h2))
        else $error("Predecrement long cost wrong.");
    cov_ea_done: cover property (@(posedge clk) disable iff (reset)
        op == `EMT_OP_EA && done);
    cov_move_wr: cover property (@(posedge clk) disable iff (reset) $rose(bus_wr));
    cov_stretch: cover property (@(posedge clk) disable iff (reset) stretch);
    // Index size is only observed here, since it has no timing effect.
    cov_idx_long: cover property (@(posedge clk) disable iff (reset)
        src_mode == `EMT_M_IDX && idx_long && done);
endmodule

/* verification/emt_mem.sv */
/*
 * Behavioural memory that answers the sequencer's read and write cycles.
 * Assumes bus_rd and bus_wr are levels that rise at the start of a burst.
 */
module emt_mem (
    // Clock.
    input  wire logic       clk,
    // Bus cycle levels from the sequencer.
    input  wire logic       bus_rd,
    input  wire logic       bus_wr,
    // Periods to hold back the first cycle of a burst, zero answers at once.
    input  wire logic [3:0] stall,
    // Answer level toward the sequencer.
    output logic            mem_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold_q = 4'h0;
    logic       act_q  = 1'b0;
    // stretch first cycle.
    // Only the first cycle of a burst is slowed, which keeps the model cheap.
    always @(posedge clk) begin
        act_q <= bus_rd | bus_wr;
        if ((bus_rd | bus_wr) && !act_q) begin
            hold_q <= stall;
        end else if (hold_q != 4'h0) begin
            hold_q <= hold_q - 4'h1;
        end
    end
    // Ready stays low only while a slow cycle is held back.
    assign mem_ready = (hold_q == 4'h0);
endmodule

/* verification/test_ea_move_cycle_timing.sv */
/*
 * Self-checking bench for the cycle sequencer: address costs, move costs,
 * wait states and refused requests. Assumes the memory model beside it.
 */
`include "emt_regs.svh"
module test_ea_move_cycle_timing;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk       = 1'b0;
    logic       reset     = 1'b1;
    logic       req       = 1'b0;
    logic [1:0] op        = 2'h0;
    logic [3:0] src_mode  = 4'h0;
    logic [3:0] dst_mode  = 4'h0;
    logic       long_sz   = 1'b0;
    logic       fetch     = 1'b0;
    logic       idx_long  = 1'b0;
    logic [3:0] stall     = 4'h0;
    logic       mem_ready;
    logic       bus_rd;
    logic       bus_wr;
    logic       busy;
    logic       done;
    logic [5:0] res_clk;
    logic [2:0] res_rd;
    logic [2:0] res_wr;
    logic [7:0] wait_cnt;
    logic       bad_req;
    int         error_cnt = 0;
    int         n_checks  = 0;
    int         n_cyc, n_rd, n_wr, late_rd, seen_busy;
    // Cost tables per mode: fetch, no fetch, destination add.
    int fc[12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
    int fr[12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
    int nc[9]  = '{0, 0, 2, 4, 4, 4, 8, 4, 8};
    int nr[9]  = '{0, 0, 0, 0, 0, 1, 1, 1, 2};
    int dc[9]  = '{0, 0, 4, 4, 4, 8, 10, 8, 12};
    int dr[9]  = '{0, 0, 0, 0, 0, 1, 1, 1, 2};

    emt_seq dut (.clk(clk), .reset(reset), .req(req), .op(op), .src_mode(src_mode),
        .dst_mode(dst_mode), .long_sz(long_sz), .fetch(fetch), .idx_long(idx_long),
        .mem_ready(mem_ready), .bus_rd(bus_rd), .bus_wr(bus_wr), .busy(busy), .done(done),
        .res_clk(res_clk), .res_rd(res_rd), .res_wr(res_wr), .wait_cnt(wait_cnt),
        .bad_req(bad_req));
    emt_mem mem (.clk(clk), .bus_rd(bus_rd), .bus_wr(bus_wr), .stall(stall),
        .mem_ready(mem_ready));

    // Free-running clock at 50 MHz.
    always #10 clk = ~clk;

    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares one value and reports a mismatch at once.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, seen);
        end
    endtask

    // Issues one request, watches the bus until done and judges the result.
    task automatic run(input logic [1:0] o, input logic [3:0] s, input logic [3:0] d,
                       input logic lg, input logic fe, input logic ix,
                       input int ec, input int er, input int ew);
        int k;
        @(posedge clk);
        req <= 1'b1;
        {op, src_mode, dst_mode, long_sz, fetch, idx_long} <= {o, s, d, lg, fe, ix};
        @(posedge clk);
        req <= 1'b0;
        n_cyc = 0;
        n_rd = 0;
        n_wr = 0;
        late_rd = 0;
        for (k = 0; k < 300; k++) begin
            @(negedge clk);
            n_cyc++;
            if (bus_rd === 1'b1 && n_wr != 0) late_rd++;
            if (bus_rd === 1'b1) n_rd++;
            if (bus_wr === 1'b1) n_wr++;
            if (done === 1'b1) break;
        end
        if (k == 300) begin
            error_cnt++;
            finish_test();
        end else begin
            check("res_clk", 16'(res_clk), 16'(ec));
            check("res_rd", 16'(res_rd), 16'(er));
            check("res_wr", 16'(res_wr), 16'(ew));
            check("cycles", 16'(n_cyc), 16'(ec) + 16'(wait_cnt) + 16'h0001);
            check("reads_first", 16'(late_rd), 16'h0000);
            if (stall == 4'h0) begin
                check("rd_periods", 16'(n_rd), 16'(4 * er));
                check("wr_periods", 16'(n_wr), 16'(4 * ew));
                check("no_waits", 16'(wait_cnt), 16'h0000);
            end
        end
    endtask

    // Address modes 2 to 11, each size, with and without fetch for modes 2 to 8, index sizes alike.
    task automatic ea_scan();
        for (int m = 2; m < 12; m++) begin
            for (int b = 0; b < 4; b++) begin
                if (b < 2 && m > 8) continue;
                if (b[1]) begin
                    run(`EMT_OP_EA, 4'(m), 4'h0, b[0], 1'b1, 1'b1,
                        fc[m] + 4 * b[0], fr[m] + b[0], 0);
                end else begin
                    run(`EMT_OP_EA, 4'(m), 4'h0, b[0], 1'b0, 1'b0, nc[m], nr[m], 0);
                end
            end
        end
    endtask

    // Every byte or word move from each source to each destination.
    task automatic move_scan();
        for (int s = 0; s < 12; s++) begin
            for (int d = 0; d < 9; d++) begin
                run(`EMT_OP_MOVE, 4'(s), 4'(d), 1'b0, 1'b1, d[0],
                    4 + fc[s] + dc[d], 1 + fr[s] + dr[d], (d > 1) ? 1 : 0);
            end
        end
    endtask

    // Slow memory adds wait states on top of the nominal totals.
    task automatic stalled();
        @(posedge clk);
        stall <= 4'h6;
        run(`EMT_OP_EA, `EMT_M_IND, 4'h0, 1'b0, 1'b1, 1'b0, 4, 1, 0);
        check("waits_read", 16'(wait_cnt != 8'h00), 16'h0001);
        run(`EMT_OP_MOVE, `EMT_M_DREG, `EMT_M_ABSL, 1'b0, 1'b1, 1'b0, 16, 3, 1);
        check("waits_move", 16'(wait_cnt != 8'h00), 16'h0001);
        @(posedge clk);
        stall <= 4'h0;
    endtask

    // A reset in mid-operation clears every output; the next request runs clean.
    task automatic reset_mid();
        @(posedge clk);
        req <= 1'b1;
        {op, src_mode, dst_mode, long_sz, fetch} <=
            {`EMT_OP_MOVE, `EMT_M_IDX, `EMT_M_ABSL, 1'b0, 1'b1};
        @(posedge clk);
        req <= 1'b0;
        repeat (6) @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check("reset_outs", 16'({bus_rd, bus_wr, busy, done, bad_req}), 16'h0000);
        check("reset_res", 16'({res_clk, res_rd, res_wr}), 16'h0000);
        check("reset_wait", 16'(wait_cnt), 16'h0000);
        run(`EMT_OP_EA, `EMT_M_IND, 4'h0, 1'b0, 1'b1, 1'b0, 4, 1, 0);
    endtask

    // A refused request pulses bad_req and never starts a bus cycle.
    task automatic refuse(input logic [1:0] o, input logic [3:0] s, input logic [3:0] d,
                          input logic lg, input logic fe);
        int hit;
        @(posedge clk);
        req <= 1'b1;
        {op, src_mode, dst_mode, long_sz, fetch} <= {o, s, d, lg, fe};
        @(posedge clk);
        req <= 1'b0;
        hit = 0;
        seen_busy = 0;
        repeat (4) begin
            @(negedge clk);
            if (bad_req === 1'b1) hit++;
            if (busy !== 1'b0 || bus_rd !== 1'b0) seen_busy++;
        end
        check("bad_req", 16'(hit), 16'h0001);
        check("idle", 16'(seen_busy), 16'h0000);
    endtask

    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        ea_scan();
        move_scan();
        stalled();
        reset_mid();
        refuse(`EMT_OP_EA, `EMT_M_PCD, 4'h0, 1'b0, 1'b0);
        refuse(`EMT_OP_EA, `EMT_M_IMM, 4'h0, 1'b0, 1'b0);
        refuse(`EMT_OP_MOVE, `EMT_M_IND, `EMT_M_DREG, 1'b1, 1'b1);
        refuse(`EMT_OP_MOVE, `EMT_M_IND, `EMT_M_PCD, 1'b0, 1'b1);
        refuse(`EMT_OP_EA, 4'hC, 4'h0, 1'b0, 1'b1);
        finish_test();
    end
endmodule
